// [logic/fbs_pkg.sv]
// constants, types and helpers shared by the fieldbus slave config/status block
package fbs_pkg;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int SETTLE_NS = 100_000;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TICKS_PER_US = 1000 / CLK_PERIOD_NS;
   // ----------------------------------------------------------------
   // switch decode
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_MIN = 8'h03;
   localparam logic [7:0] ADDR_MAX = 8'hEF;
   localparam logic [3:0] ADDR_HI_RSVD = 4'hF;
   localparam logic [1:0] LEN_SEL_32 = 2'h1;
   localparam logic [1:0] LEN_SEL_48 = 2'h2;
   localparam logic [5:0] LEN_BYTES_32 = 6'h20;
   localparam logic [5:0] LEN_BYTES_48 = 6'h30;
   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CFG = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam int CFG_ADDR_LSB = 0;
   localparam int CFG_LEN_LSB = 8;
   localparam int CFG_ADDR_OK_BIT = 16;
   localparam int CFG_LEN_OK_BIT = 17;
   localparam int CFG_DONE_BIT = 18;
   localparam int CFG_INVALID_BIT = 19;
   localparam int CTRL_JOIN_BIT = 0;
   localparam int CTRL_TCYC_LSB = 4;
   localparam logic [3:0] CTRL_TCYC_RST = 4'h3;
   localparam logic CTRL_JOIN_RST = 1'b1;
   localparam int STAT_LINK0_BIT = 0;
   localparam int STAT_LINK1_BIT = 1;
   localparam int STAT_ERR_BIT = 2;
   localparam int STAT_CONN_BIT = 3;
   localparam int STAT_JOIN_BIT = 4;
   // ----------------------------------------------------------------
   // transmission cycle codes: 0..2 = 250/500/750 us, 3..9 = 1.0..4.0 ms
   // ----------------------------------------------------------------
   localparam logic [3:0] TCYC_IDX_MAX = 4'h9;
   localparam logic [3:0] TCYC_IDX_MS = 4'h3;
   localparam logic [12:0] TCYC_STEP_SHORT = 13'h00FA;
   localparam logic [12:0] TCYC_BASE_MS = 13'h03E8;
   localparam logic [12:0] TCYC_STEP_MS = 13'h01F4;

   typedef enum logic [1:0] {
      FBS_CAP_SYNC = 2'b00,
      FBS_CAP_SETTLE = 2'b01,
      FBS_CAP_DONE = 2'b11
   } fbs_cap_st_t;

   function automatic logic [12:0] fbs_tcyc_us(input logic [3:0] idx);
      logic [12:0] i;
      i = {9'h000, idx};
      if (idx < TCYC_IDX_MS)
         return 13'((i + 13'h0001) * TCYC_STEP_SHORT);
      else
         return 13'(TCYC_BASE_MS + (i - 13'(TCYC_IDX_MS)) * TCYC_STEP_MS);
   endfunction

   function automatic logic fbs_addr_ok(input logic [7:0] a);
      return (a >= ADDR_MIN) && (a <= ADDR_MAX) && (a[7:4] != ADDR_HI_RSVD);
   endfunction
endpackage

// [logic/fbs_cfg_if.sv]
// latched power-up configuration passed from the capture unit to the top
`timescale 1ns/1ps
`default_nettype none
interface fbs_cfg_if;
   logic [7:0] sta_addr;
   logic [1:0] len_sel;
   logic [5:0] payload_bytes;
   logic addr_ok;
   logic len_ok;
   logic done;
   modport src (output sta_addr, len_sel, payload_bytes, addr_ok, len_ok, done);
   modport dst (input sta_addr, len_sel, payload_bytes, addr_ok, len_ok, done);
endinterface
`default_nettype wire

// [logic/fbs_cfg_latch.sv]
// one-shot capture and decode of the address and payload switches
`timescale 1ns/1ps
`default_nettype none
module fbs_cfg_latch (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // switch pins
   input wire logic [3:0] addr_rotary_a,
   input wire logic [3:0] addr_rotary_b,
   input wire logic [1:0] payload_len_dip,
   // captured configuration
   fbs_cfg_if.src cfg
);
   localparam int CW = $clog2(fbs_pkg::SETTLE_CYC + 1);
   localparam logic [CW-1:0] SETTLE_LAST = CW'(fbs_pkg::SETTLE_CYC - 1);

   logic [9:0] s1_q;
   logic [9:0] s2_q;
   logic [9:0] hold_q;
   logic [CW-1:0] cnt_q;
   fbs_pkg::fbs_cap_st_t st_q;

   // ----------------------------------------------------------------
   // pin synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s1_q <= 10'h000;
         s2_q <= 10'h000;
      end
      else
      begin
         s1_q <= {addr_rotary_a, addr_rotary_b, payload_len_dip};
         s2_q <= s1_q;
      end
   end

   // ----------------------------------------------------------------
   // settle, then capture once; the counter restarts on any bounce
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_q <= fbs_pkg::FBS_CAP_SYNC;
         cnt_q <= '0;
         hold_q <= 10'h000;
      end
      else
      begin
         case (st_q)
            fbs_pkg::FBS_CAP_SYNC:
            begin
               hold_q <= s2_q;
               cnt_q <= '0;
               st_q <= fbs_pkg::FBS_CAP_SETTLE;
            end
            fbs_pkg::FBS_CAP_SETTLE:
            begin
               if (s2_q != hold_q)
               begin
                  hold_q <= s2_q;
                  cnt_q <= '0;
               end
               else if (cnt_q == SETTLE_LAST)
                  st_q <= fbs_pkg::FBS_CAP_DONE;
               else
                  cnt_q <= cnt_q + 1'b1;
            end
            fbs_pkg::FBS_CAP_DONE:
               st_q <= fbs_pkg::FBS_CAP_DONE;
            default:
               st_q <= fbs_pkg::FBS_CAP_SYNC;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // decode at the capture edge only
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cfg.sta_addr <= 8'h00;
         cfg.len_sel <= 2'h0;
         cfg.payload_bytes <= 6'h00;
         cfg.addr_ok <= 1'b0;
         cfg.len_ok <= 1'b0;
         cfg.done <= 1'b0;
      end
      else if (st_q == fbs_pkg::FBS_CAP_SETTLE && s2_q == hold_q && cnt_q == SETTLE_LAST)
      begin
         cfg.done <= 1'b1;
         cfg.sta_addr <= hold_q[9:2];
         cfg.addr_ok <= fbs_pkg::fbs_addr_ok(hold_q[9:2]);
         cfg.len_sel <= hold_q[1:0];
         cfg.len_ok <= (hold_q[1:0] == fbs_pkg::LEN_SEL_32)
                       || (hold_q[1:0] == fbs_pkg::LEN_SEL_48);
         case (hold_q[1:0])
            fbs_pkg::LEN_SEL_32: cfg.payload_bytes <= fbs_pkg::LEN_BYTES_32;
            fbs_pkg::LEN_SEL_48: cfg.payload_bytes <= fbs_pkg::LEN_BYTES_48;
            default: cfg.payload_bytes <= 6'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   cfg_frozen_a: assert property (@(posedge clk) disable iff (!rst_b)
      $past(cfg.done) |-> ($stable(cfg.sta_addr) && $stable(cfg.len_sel) && cfg.done))
      else $error("configuration changed after capture");
   addr_range_a: assert property (@(posedge clk) disable iff (!rst_b)
      (cfg.done && (cfg.sta_addr < 8'h03 || cfg.sta_addr[7:4] == 4'hF)) |-> !cfg.addr_ok)
      else $error("reserved station address accepted");
   len_decode_a: assert property (@(posedge clk) disable iff (!rst_b)
      cfg.done |-> (cfg.len_ok == (cfg.len_sel[0] ^ cfg.len_sel[1]))
                   && (cfg.len_sel != 2'h2 || cfg.payload_bytes == 6'h30))
      else $error("payload length decode wrong");
endmodule
`default_nettype wire

// [logic/fbs_slave_cfg.sv]
// fieldbus slave configuration capture, indicators and APB register file
`timescale 1ns/1ps
`default_nettype none
module fbs_slave_cfg #(
   parameter int TICKS_PER_US = fbs_pkg::TICKS_PER_US
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // apb slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // switch pins
   input wire logic [3:0] addr_rotary_a,
   input wire logic [3:0] addr_rotary_b,
   input wire logic [1:0] payload_len_dip,
   // link pins
   input wire logic pwr_ok,
   input wire logic [1:0] phy_link,
   // protocol engine, same clock
   input wire logic comm_err,
   input wire logic conn_up,
   // indicators
   output logic link_ind_port0,
   output logic link_ind_port1,
   output logic err_ind,
   output logic conn_ind,
   // configuration to the protocol engine
   output logic cfg_invalid,
   output logic join_allowed,
   output logic [7:0] station_addr,
   output logic [5:0] payload_bytes,
   output logic [12:0] tcyc_us,
   output logic cyc_tick
);
   fbs_cfg_if cfg ();

   logic [2:0] ls1_q;
   logic [2:0] ls2_q;
   logic join_en_q;
   logic [3:0] tcyc_idx_q;
   logic [16:0] tick_cnt_q;
   logic [16:0] period_last;
   logic wr_en;
   logic rd_setup;
   logic map_hit;
   logic err_clr;

   fbs_cfg_latch u_latch (
      .clk(clk),
      .rst_b(rst_b),
      .addr_rotary_a(addr_rotary_a),
      .addr_rotary_b(addr_rotary_b),
      .payload_len_dip(payload_len_dip),
      .cfg(cfg)
   );

   // ----------------------------------------------------------------
   // apb decode; zero wait states
   // ----------------------------------------------------------------
   assign map_hit = (paddr == fbs_pkg::OFS_CFG) || (paddr == fbs_pkg::OFS_CTRL)
                    || (paddr == fbs_pkg::OFS_STAT);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !map_hit;
   assign wr_en = psel && penable && pwrite && map_hit;
   assign rd_setup = psel && !penable && !pwrite;
   assign err_clr = wr_en && (paddr == fbs_pkg::OFS_STAT) && pstrb[0]
                    && pwdata[fbs_pkg::STAT_ERR_BIT];

   // ----------------------------------------------------------------
   // pin synchroniser for power and phy link
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ls1_q <= 3'h0;
         ls2_q <= 3'h0;
      end
      else
      begin
         ls1_q <= {pwr_ok, phy_link};
         ls2_q <= ls1_q;
      end
   end

   // ----------------------------------------------------------------
   // control register; an out-of-range cycle code leaves the old one
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         join_en_q <= fbs_pkg::CTRL_JOIN_RST;
         tcyc_idx_q <= fbs_pkg::CTRL_TCYC_RST;
      end
      else if (wr_en && paddr == fbs_pkg::OFS_CTRL && pstrb[0])
      begin
         join_en_q <= pwdata[fbs_pkg::CTRL_JOIN_BIT];
         if (pwdata[fbs_pkg::CTRL_TCYC_LSB +: 4] <= fbs_pkg::TCYC_IDX_MAX)
            tcyc_idx_q <= pwdata[fbs_pkg::CTRL_TCYC_LSB +: 4];
      end
   end

   // ----------------------------------------------------------------
   // indicators and configuration outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         link_ind_port0 <= 1'b0;
         link_ind_port1 <= 1'b0;
         cfg_invalid <= 1'b0;
         join_allowed <= 1'b0;
         conn_ind <= 1'b0;
         station_addr <= 8'h00;
         payload_bytes <= 6'h00;
         tcyc_us <= 13'h0000;
      end
      else
      begin
         link_ind_port0 <= ls2_q[2] && ls2_q[0];
         link_ind_port1 <= ls2_q[2] && ls2_q[1];
         cfg_invalid <= cfg.done && !(cfg.addr_ok && cfg.len_ok);
         // join only once a sound setting has been captured
         join_allowed <= cfg.done && cfg.addr_ok && cfg.len_ok && join_en_q;
         conn_ind <= conn_up && join_allowed;
         station_addr <= cfg.sta_addr;
         payload_bytes <= cfg.payload_bytes;
         tcyc_us <= fbs_pkg::fbs_tcyc_us(tcyc_idx_q);
      end
   end

   // sticky until cleared; a new error in the clear cycle wins
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         err_ind <= 1'b0;
      else if (comm_err)
         err_ind <= 1'b1;
      else if (err_clr)
         err_ind <= 1'b0;
   end

   // ----------------------------------------------------------------
   // transmission cycle timebase, only while joined
   // ----------------------------------------------------------------
   assign period_last = 17'(tcyc_us * 17'(TICKS_PER_US) - 17'h0_0001);

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tick_cnt_q <= 17'h0_0000;
         cyc_tick <= 1'b0;
      end
      else if (!join_allowed)
      begin
         tick_cnt_q <= 17'h0_0000;
         cyc_tick <= 1'b0;
      end
      else if (tick_cnt_q >= period_last)
      begin
         tick_cnt_q <= 17'h0_0000;
         cyc_tick <= 1'b1;
      end
      else
      begin
         tick_cnt_q <= tick_cnt_q + 17'h0_0001;
         cyc_tick <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // read data, registered in the setup phase
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         prdata <= 32'h0000_0000;
      else if (rd_setup)
      begin
         prdata <= 32'h0000_0000;
         case (paddr)
            fbs_pkg::OFS_CFG:
            begin
               prdata[fbs_pkg::CFG_ADDR_LSB +: 8] <= cfg.sta_addr;
               prdata[fbs_pkg::CFG_LEN_LSB +: 6] <= cfg.payload_bytes;
               prdata[fbs_pkg::CFG_ADDR_OK_BIT] <= cfg.addr_ok;
               prdata[fbs_pkg::CFG_LEN_OK_BIT] <= cfg.len_ok;
               prdata[fbs_pkg::CFG_DONE_BIT] <= cfg.done;
               prdata[fbs_pkg::CFG_INVALID_BIT] <= cfg_invalid;
            end
            fbs_pkg::OFS_CTRL:
            begin
               prdata[fbs_pkg::CTRL_JOIN_BIT] <= join_en_q;
               prdata[fbs_pkg::CTRL_TCYC_LSB +: 4] <= tcyc_idx_q;
            end
            fbs_pkg::OFS_STAT:
            begin
               prdata[fbs_pkg::STAT_LINK0_BIT] <= link_ind_port0;
               prdata[fbs_pkg::STAT_LINK1_BIT] <= link_ind_port1;
               prdata[fbs_pkg::STAT_ERR_BIT] <= err_ind;
               prdata[fbs_pkg::STAT_CONN_BIT] <= conn_ind;
               prdata[fbs_pkg::STAT_JOIN_BIT] <= join_allowed;
            end
            default:
               prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   link_follows_pin_a: assert property (@(posedge clk) disable iff (!rst_b)
      (pwr_ok && phy_link[0]) [*4] |-> link_ind_port0)
      else $error("link indicator 0 not lit with power and link");
   link_needs_pwr_a: assert property (@(posedge clk) disable iff (!rst_b)
      (!pwr_ok) [*4] |-> (!link_ind_port0 && !link_ind_port1))
      else $error("link indicator lit without power");
   err_sets_a: assert property (@(posedge clk) disable iff (!rst_b)
      comm_err |=> err_ind)
      else $error("communication error not shown");
   err_holds_a: assert property (@(posedge clk) disable iff (!rst_b)
      (err_ind && !err_clr) |=> err_ind)
      else $error("error indicator dropped without clear");
   conn_follows_a: assert property (@(posedge clk) disable iff (!rst_b)
      (join_allowed && conn_up) |=> conn_ind)
      else $error("connection indicator not lit with connection");
   conn_drops_a: assert property (@(posedge clk) disable iff (!rst_b)
      !(join_allowed && conn_up) |=> !conn_ind)
      else $error("connection indicator lit without connection");
   invalid_blocks_a: assert property (@(posedge clk) disable iff (!rst_b)
      cfg_invalid |-> (!join_allowed && !conn_ind && !cyc_tick))
      else $error("joined with reserved configuration");
   tcyc_legal_a: assert property (@(posedge clk) disable iff (!rst_b)
      $changed(tcyc_us) |-> (tcyc_us == 13'h00FA || tcyc_us == 13'h01F4
         || tcyc_us == 13'h02EE || (tcyc_us >= 13'h03E8 && tcyc_us <= 13'h0FA0
         && (tcyc_us % 13'h01F4) == 13'h0000)))
      else $error("illegal transmission cycle");
   tick_gap_a: assert property (@(posedge clk) disable iff (!rst_b)
      (cyc_tick && tcyc_us == 13'h00FA && $stable(tcyc_us) && join_allowed)
         |=> (!cyc_tick) [*8])
      else $error("cycle tick too early");
   unmapped_err_a: assert property (@(posedge clk) disable iff (!rst_b)
      (psel && penable && paddr == 8'h0C) |-> pslverr)
      else $error("unmapped access not flagged");
endmodule
`default_nettype wire

// [dv/fbs_master_model.sv]
// behavioural fieldbus master seen from the slave's protocol-engine inputs
`timescale 1ns/1ps
`default_nettype none
module fbs_master_model #(
   parameter logic [7:0] OTHER_ADDR = 8'h10
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // slave configuration
   input wire logic join_allowed,
   input wire logic [7:0] station_addr,
   // bench commands
   input wire logic cmd_conn,
   input wire logic cmd_err,
   // towards the slave
   output logic conn_up,
   output logic comm_err
);
   // ----------------------------------------------------------------
   // connection and error reporting
   // ----------------------------------------------------------------
   // a second slave owns OTHER_ADDR; a clash is never connected
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         conn_up <= 1'b0;
      else
         conn_up <= cmd_conn && join_allowed && (station_addr != OTHER_ADDR);
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         comm_err <= 1'b0;
      else
         comm_err <= cmd_err;
   end
endmodule
`default_nettype wire

// [dv/test_fbs_slave_cfg.sv]
// self-checking bench for the fieldbus slave configuration and status block
`timescale 1ns/1ps
`default_nettype none
module test_fbs_slave_cfg;
   logic clk, rst_b, psel, penable, pwrite, pready, pslverr, pwr_ok, comm_err, conn_up;
   logic [7:0] paddr, station_addr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb, rot_a, rot_b;
   logic [1:0] dip, phy_link;
   logic link0, link1, err_ind, conn_ind, cfg_invalid, join_allowed, cyc_tick, err, cmd_conn, cmd_err;
   logic [5:0] payload_bytes;
   logic [12:0] tcyc_us;
   int n_fail, cmp_count;
   // ----------------------------------------------------------------
   // design and far side
   // ----------------------------------------------------------------
   fbs_slave_cfg #(.TICKS_PER_US(1)) dut (.clk(clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .addr_rotary_a(rot_a), .addr_rotary_b(rot_b),
      .payload_len_dip(dip), .pwr_ok(pwr_ok), .phy_link(phy_link), .comm_err(comm_err),
      .conn_up(conn_up), .link_ind_port0(link0), .link_ind_port1(link1), .err_ind(err_ind),
      .conn_ind(conn_ind), .cfg_invalid(cfg_invalid), .join_allowed(join_allowed),
      .station_addr(station_addr), .payload_bytes(payload_bytes), .tcyc_us(tcyc_us),
      .cyc_tick(cyc_tick));
   fbs_master_model mst (.clk(clk), .rst_b(rst_b), .join_allowed(join_allowed),
      .station_addr(station_addr), .cmd_conn(cmd_conn), .cmd_err(cmd_err), .conn_up(conn_up),
      .comm_err(comm_err));
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // waits for pready, never assuming a latency
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 50; i++)
      begin
         @(posedge clk);
         if (pready === 1'b1)
            break;
      end
      if (i == 50)
      begin
         n_fail++;
         print_verdict();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic power_up(input logic [7:0] a, input logic [1:0] d);
      int i;
      rst_b <= 1'b0;
      rot_a <= a[7:4];
      rot_b <= a[3:0];
      dip <= d;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      for (i = 0; i < 1500; i++)
      begin
         apb(1'b0, fbs_pkg::OFS_CFG, 32'h0000_0000);
         if (rd[fbs_pkg::CFG_DONE_BIT] === 1'b1)
            break;
      end
      if (i == 1500)
      begin
         n_fail++;
         print_verdict();
      end
      repeat (2) @(posedge clk);
   endtask
   // edges between two ticks; the bench runs one tick per microsecond
   task automatic tick_gap(input logic [12:0] exp);
      int i, t1;
      t1 = -1;
      for (i = 0; i < 9000; i++)
      begin
         @(posedge clk);
         if (cyc_tick === 1'b1 && t1 >= 0)
            break;
         if (cyc_tick === 1'b1)
            t1 = i;
      end
      check("tick_gap", (i < 9000) ? 32'(i - t1) : 32'h0000_0000, 32'(exp));
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   logic [7:0] c_addr [5] = '{8'h03, 8'hEF, 8'h02, 8'hF0, 8'h5A};
   logic [1:0] c_dip [5] = '{2'b11, 2'b10, 2'b00, 2'b01, 2'b01};
   logic [12:0] c_us [10] = '{13'h00FA, 13'h01F4, 13'h02EE, 13'h03E8, 13'h05DC, 13'h07D0,
      13'h09C4, 13'h0BB8, 13'h0DAC, 13'h0FA0};
   logic aok, lok;
   logic [5:0] bytes;
   logic [31:0] exp, msk;
   int k;
   initial
   begin
      n_fail = 0;
      cmp_count = 0;
      rst_b = 1'b0;
      {psel, penable, pwrite, pwr_ok, cmd_conn, cmd_err} = '0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      pstrb = 4'hF;
      {rot_a, rot_b, dip, phy_link} = '0;
      // each setting is only taken after a fresh power-up
      for (k = 0; k < 5; k++)
      begin
         power_up(c_addr[k], c_dip[k]);
         aok = c_addr[k] >= 8'h03 && c_addr[k] <= 8'hEF && c_addr[k][7:4] != 4'hF;
         lok = c_dip[k] == 2'b01 || c_dip[k] == 2'b10;
         bytes = c_dip[k] == 2'b01 ? 6'h20 : (c_dip[k] == 2'b10 ? 6'h30 : 6'h00);
         exp = {12'h000, !(aok && lok), 1'b1, lok, aok, 2'b00, bytes, c_addr[k]};
         msk = aok ? 32'hFFFF_FFFF : 32'hFFFF_FF00;
         apb(1'b0, fbs_pkg::OFS_CFG, 32'h0000_0000);
         check("cfg_reg", rd & msk, exp & msk);
         check("payload", payload_bytes, bytes);
         check("invalid", cfg_invalid, !(aok && lok));
         check("join", join_allowed, aok && lok);
         if (aok)
            check("station", station_addr, c_addr[k]);
      end
      apb(1'b0, fbs_pkg::OFS_CTRL, 32'h0000_0000);
      check("ctrl_rst", rd, 32'h0000_0031);
      rot_a <= 4'h0;
      dip <= 2'b11;
      repeat (1100) @(posedge clk);
      apb(1'b0, fbs_pkg::OFS_CFG, 32'h0000_0000);
      check("cfg_hold", rd, 32'h0007_205A);
      check("station_hold", station_addr, 8'h5A);
      // every cycle code, then a refused one that keeps the last
      for (k = 0; k < 10; k++)
      begin
         apb(1'b1, fbs_pkg::OFS_CTRL, 32'(k * 16 + 1));
         repeat (2) @(posedge clk);
         check("tcyc", tcyc_us, c_us[k]);
      end
      tick_gap(13'h0FA0);
      apb(1'b1, fbs_pkg::OFS_CTRL, 32'h0000_00A1);
      repeat (2) @(posedge clk);
      check("tcyc_keep", tcyc_us, 13'h0FA0);
      apb(1'b1, fbs_pkg::OFS_CTRL, 32'h0000_0001);
      // link indicators over every power and port combination
      for (k = 0; k < 8; k++)
      begin
         pwr_ok <= k[2];
         phy_link <= k[1:0];
         repeat (4) @(posedge clk);
         check("link0", link0, k[2] & k[0]);
         check("link1", link1, k[2] & k[1]);
      end
      cmd_err <= 1'b1;
      @(posedge clk);
      cmd_err <= 1'b0;
      repeat (3) @(posedge clk);
      check("err_set", err_ind, 1'b1);
      apb(1'b1, fbs_pkg::OFS_STAT, 32'h0000_0004);
      repeat (2) @(posedge clk);
      check("err_clr", err_ind, 1'b0);
      cmd_conn <= 1'b1;
      repeat (4) @(posedge clk);
      check("conn_on", conn_ind, 1'b1);
      apb(1'b0, fbs_pkg::OFS_STAT, 32'h0000_0000);
      check("stat", rd, 32'h0000_001B);
      apb(1'b1, fbs_pkg::OFS_CTRL, 32'h0000_0000);
      repeat (4) @(posedge clk);
      check("conn_off", conn_ind, 1'b0);
      apb(1'b0, 8'h0C, 32'h0000_0000);
      check("unmapped_err", err, 1'b1);
      check("unmapped_data", rd, 32'h0000_0000);
      print_verdict();
   end
endmodule
`default_nettype wire
